// ---- mcu_core.sv ----
// Functional notes
// RL1: One 16-bit instruction per 200 ns cycle over a dedicated instruction bus.
// RL2: Fetched word latched in instruction register, decoded by opcode field.
// RL3: Next address formed mid-cycle from counter, held in address register.
// RL4: Timing from one oscillator at twice instruction rate, two periods.
// RL5: Sources: sixteen registers, peripheral bus, or instruction constant.
// RL6: Rotate and mask form first operand; auxiliary register is second.
// RL7: Result goes to an internal register or out on peripheral bus.
// RL8: Sixteen 8-bit registers; three special for select and flags.
// RL9: Peripherals reached over 8-bit bus with control lines.
// RL10: Select command with address picks one of 256 ports, sticky.
// RL11: Write command high when core drives data, low when reading.
// RL12: Ports respond only while their bank line is low.
// RL13: Reset clears counter and address, stops master clock, banks high.
// RL14: Next fetch overlaps current execution, no wait cycles.
// RL15: Shared bus lines carry address and data, released when idle.
module mcu_core (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic [12:0] instruction_address_lines,
    input wire logic [15:0] instruction_word_lines,
    input wire logic [7:0] peripheral_vector_bus_in,
    output logic [7:0] peripheral_vector_bus_out,
    output logic peripheral_vector_bus_oe,
    output logic port_select_command,
    output logic bus_write_command,
    output logic left_port_group_enable_n,
    output logic right_port_group_enable_n,
    output logic master_clock
);

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [7:0] rot_right(input logic [7:0] v,
                                             input logic [2:0] n);
        logic [15:0] t;
        t = {v, v} >> n;
        return t[7:0];
    endfunction

    function automatic logic [7:0] mask_low(input logic [7:0] v,
                                            input logic [2:0] len);
        logic [7:0] m;
        m = (len == 3'h0) ? mcu_core_pkg::MASK_ALL
                          : ~(mcu_core_pkg::MASK_ALL << len);
        return v & m;
    endfunction

    // =========================================================
    // State
    // =========================================================
    logic [5:0] phase_q;
    mcu_core_pkg::run_e run_q;
    mcu_core_pkg::instr_s ir_q;
    logic [12:0] pc_q;
    logic [12:0] addr_q;
    logic [7:0] regs_q [mcu_core_pkg::NREG];
    logic [7:0] bus_in_q;
    mcu_core_pkg::bus_ctl_s ctl_q;
    logic [7:0] bus_out_q;
    logic bus_oe_q;
    logic mclk_q;

    // Local aliases, declared ahead of their first use
    localparam logic [7:0] MASK_INV = 8'hFF;
    localparam logic [3:0] REG_SEL_LEFT = mcu_core_pkg::REG_SEL_LEFT;
    localparam logic [3:0] REG_SEL_RIGHT = mcu_core_pkg::REG_SEL_RIGHT;

    logic end_cyc;
    logic mid_cyc;
    logic smp_cyc;
    logic exec;
    logic src_bus;
    logic [4:0] dest;
    logic [7:0] imm;
    logic [7:0] op1;
    logic [8:0] sum;
    logic [7:0] result;
    logic writes;
    logic [12:0] addr_d;

    assign end_cyc = (phase_q == mcu_core_pkg::PH_LAST);
    assign mid_cyc = (phase_q == mcu_core_pkg::PH_HALF);
    assign smp_cyc = (phase_q == mcu_core_pkg::PH_SAMPLE);
    assign exec = (run_q == mcu_core_pkg::ST_RUN);

    // =========================================================
    // Cycle timing
    // =========================================================
    // RL4: two oscillator halves per cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n || end_cyc) begin
            phase_q <= mcu_core_pkg::PH_FIRST;
        end else begin
            phase_q <= phase_q + 6'h01;
        end
    end

    // RL13: master clock held low in reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n || end_cyc) begin
            mclk_q <= 1'b0;
        end else if (mid_cyc) begin
            mclk_q <= 1'b1;
        end
    end

    // =========================================================
    // Fetch and decode
    // =========================================================
    // RL2: latch fetched word at cycle end
    // RL1: word taken from instruction bus only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            run_q <= mcu_core_pkg::ST_FILL;
            ir_q <= mcu_core_pkg::instr_s'(16'h0000);
            pc_q <= mcu_core_pkg::ADDR_RST;
        end else if (end_cyc) begin
            run_q <= mcu_core_pkg::ST_RUN;
            ir_q <= mcu_core_pkg::instr_s'(instruction_word_lines);
            pc_q <= addr_q;
        end
    end

    // RL5: operand source select
    // RL6: rotate registers, mask bus data
    always_comb begin
        src_bus = ir_q.src[mcu_core_pkg::LOC_BUS_BIT];
        imm = {ir_q.rot, ir_q.dst};
        if (src_bus) begin
            op1 = mask_low(bus_in_q, ir_q.rot);
        end else begin
            op1 = rot_right(regs_q[ir_q.src[3:0]], ir_q.rot);
        end
        sum = {1'b0, op1} + {1'b0, regs_q[mcu_core_pkg::REG_AUX]};
        unique case (ir_q.op)
            mcu_core_pkg::OP_ADD: result = sum[7:0];
            mcu_core_pkg::OP_AND: result = op1 & regs_q[mcu_core_pkg::REG_AUX];
            mcu_core_pkg::OP_XOR: result = op1 ^ regs_q[mcu_core_pkg::REG_AUX];
            mcu_core_pkg::OP_XMIT: result = imm;
            default: result = op1;
        endcase
        dest = (ir_q.op == mcu_core_pkg::OP_XMIT) ? ir_q.src : ir_q.dst;
        writes = exec && (ir_q.op inside {mcu_core_pkg::OP_MOVE,
                 mcu_core_pkg::OP_ADD, mcu_core_pkg::OP_AND,
                 mcu_core_pkg::OP_XOR, mcu_core_pkg::OP_XMIT});
    end

    // RL3: next address from jump target or increment
    always_comb begin
        addr_d = pc_q + mcu_core_pkg::ADDR_STEP;
        if (!exec) begin
            addr_d = addr_q;
        end else if (ir_q.op == mcu_core_pkg::OP_JMP) begin
            addr_d = {ir_q.src, ir_q.rot, ir_q.dst};
        end else if (ir_q.op == mcu_core_pkg::OP_NZT && op1 != 8'h00) begin
            addr_d = {pc_q[12:8], imm};
        end
    end

    // RL14: new address out mid-cycle so fetch overlaps execute
    // RL13: address cleared in reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_q <= mcu_core_pkg::ADDR_RST;
        end else if (mid_cyc) begin
            addr_q <= addr_d;
        end
    end

    // =========================================================
    // Register file
    // =========================================================
    // RL8: sixteen registers, carry kept in flag register
    // RL7: result stored when destination is internal
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < mcu_core_pkg::NREG; i++) begin
                regs_q[i] <= mcu_core_pkg::DATA_RST;
            end
        end else if (end_cyc && writes) begin
            if (ir_q.op == mcu_core_pkg::OP_ADD) begin
                regs_q[mcu_core_pkg::REG_FLAG] <= {7'h00, sum[8]};
            end
            if (!dest[mcu_core_pkg::LOC_BUS_BIT]) begin
                regs_q[dest[3:0]] <= result;
            end
        end
    end

    // =========================================================
    // Peripheral vector bus
    // =========================================================
    // Bus lines are active low; sampled before the core may drive them
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_in_q <= mcu_core_pkg::DATA_RST;
        end else if (smp_cyc) begin
            bus_in_q <= ~peripheral_vector_bus_in;
        end
    end

    // RL9: control lines per cycle half
    // RL11: write command only while core drives data
    // RL12: bank line low only for the addressed group
    // RL10: select when writing a select register
    // RL15: bus released outside the second half drive window
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q <= mcu_core_pkg::BUS_IDLE;
            bus_out_q <= MASK_INV;
            bus_oe_q <= 1'b0;
        end else if (end_cyc) begin
            ctl_q <= mcu_core_pkg::BUS_IDLE;
            bus_oe_q <= 1'b0;
            bus_out_q <= MASK_INV;
        end else if (phase_q == mcu_core_pkg::PH_FIRST && exec && src_bus
                     && ir_q.op != mcu_core_pkg::OP_XMIT
                     && ir_q.op != mcu_core_pkg::OP_JMP) begin
            ctl_q.lb_n <= ir_q.src[mcu_core_pkg::LOC_BANK_BIT];
            ctl_q.rb_n <= ~ir_q.src[mcu_core_pkg::LOC_BANK_BIT];
        end else if (mid_cyc) begin
            ctl_q <= mcu_core_pkg::BUS_IDLE;
            if (writes && dest[mcu_core_pkg::LOC_BUS_BIT]) begin
                ctl_q.wc <= 1'b1;
                ctl_q.lb_n <= dest[mcu_core_pkg::LOC_BANK_BIT];
                ctl_q.rb_n <= ~dest[mcu_core_pkg::LOC_BANK_BIT];
                bus_out_q <= ~result;
                bus_oe_q <= 1'b1;
            end else if (writes && (dest == {1'b0, REG_SEL_LEFT}
                                    || dest == {1'b0, REG_SEL_RIGHT})) begin
                ctl_q.sc <= 1'b1;
                ctl_q.lb_n <= dest[mcu_core_pkg::LOC_BANK_BIT];
                ctl_q.rb_n <= ~dest[mcu_core_pkg::LOC_BANK_BIT];
                bus_out_q <= ~result;
                bus_oe_q <= 1'b1;
            end
        end
    end

    assign instruction_address_lines = addr_q;
    assign peripheral_vector_bus_out = bus_out_q;
    assign peripheral_vector_bus_oe = bus_oe_q;
    assign port_select_command = ctl_q.sc;
    assign bus_write_command = ctl_q.wc;
    assign left_port_group_enable_n = ctl_q.lb_n;
    assign right_port_group_enable_n = ctl_q.rb_n;
    assign master_clock = mclk_q;

    // =========================================================
    // Checks
    // =========================================================
    sequence seq_select_issue;
        mid_cyc && writes && dest == {1'b0, REG_SEL_LEFT};
    endsequence

    sequence seq_select_held;
        (port_select_command && !left_port_group_enable_n
         && peripheral_vector_bus_oe)[*8];
    endsequence

    a_cycle_wrap_len: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL1
        mid_cyc |-> ##19 end_cyc ##1 (phase_q == 6'h00))
        else $error("instruction cycle length wrong");
    a_mclk_second_half: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
        $past(rst_n) |-> master_clock == (phase_q > mcu_core_pkg::PH_HALF))
        else $error("master clock not in second half");
    a_reset_outputs: assert property (@(posedge ref_clk) // RL13
        !rst_n |=> (instruction_address_lines == 13'h0000 && !master_clock
                    && left_port_group_enable_n && right_port_group_enable_n))
        else $error("reset state not applied");
    a_ir_latch: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL2
        end_cyc |=> ir_q == $past(instruction_word_lines))
        else $error("instruction not latched");
    a_jump_target: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
        (mid_cyc && exec && ir_q.op == mcu_core_pkg::OP_JMP)
        |=> instruction_address_lines == $past({ir_q.src, ir_q.rot, ir_q.dst}))
        else $error("jump address wrong");
    a_step_next: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL14
        (mid_cyc && exec && ir_q.op == mcu_core_pkg::OP_MOVE)
        |=> instruction_address_lines == $past(pc_q) + 13'h0001)
        else $error("sequential address wrong");
    a_select_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
        seq_select_issue |=> seq_select_held)
        else $error("select command not driven");
    a_write_drives: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL11
        bus_write_command |-> peripheral_vector_bus_oe && !port_select_command)
        else $error("write command without drive");
    a_bus_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
        (phase_q <= mcu_core_pkg::PH_HALF) |-> !peripheral_vector_bus_oe)
        else $error("bus driven in first half");
    a_bank_active: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
        (bus_write_command || port_select_command)
        |-> (left_port_group_enable_n != right_port_group_enable_n))
        else $error("no single bank for transfer");
    a_add_aux: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
        (end_cyc && exec && ir_q.op == mcu_core_pkg::OP_ADD && !ir_q.dst[4]
         && ir_q.dst[3:0] != 4'h8 && ir_q.dst[3:0] != 4'h0)
        |=> regs_q[$past(ir_q.dst[3:0])]
            == 8'($past(op1) + $past(regs_q[0])))
        else $error("sum with auxiliary wrong");
    a_result_to_bus: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
        (mid_cyc && writes && dest[4]) |=> bus_write_command
        && peripheral_vector_bus_out == ~$past(result))
        else $error("bus result wrong");

endmodule // mcu_core

// ---- mcu_core_pkg.sv ----
package mcu_core_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 5;
    localparam int CYCLE_NS = 200;
    localparam int OSC_PER_CYCLE = 2;
    localparam int CYCLE_CLKS = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CLKS = CYCLE_CLKS / OSC_PER_CYCLE;
    localparam logic [5:0] PH_FIRST = 6'h00;
    localparam logic [5:0] PH_LAST = 6'(CYCLE_CLKS - 1);
    localparam logic [5:0] PH_HALF = 6'(HALF_CLKS);
    localparam logic [5:0] PH_SAMPLE = 6'(HALF_CLKS - 1);

    // =========================================================
    // Widths, special registers, reset values
    // =========================================================
    localparam int AW = 13;
    localparam int DW = 8;
    localparam int NREG = 16;
    localparam logic [3:0] REG_AUX = 4'h0;
    localparam logic [3:0] REG_SEL_LEFT = 4'h7;
    localparam logic [3:0] REG_FLAG = 4'h8;
    localparam logic [3:0] REG_SEL_RIGHT = 4'hF;
    localparam logic [12:0] ADDR_RST = 13'h0000;
    localparam logic [12:0] ADDR_STEP = 13'h0001;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    // Operand location field: bit 4 picks the vector bus, bit 3 the bank
    localparam int LOC_BUS_BIT = 4;
    localparam int LOC_BANK_BIT = 3;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [2:0] {
        OP_MOVE = 3'h0,
        OP_ADD = 3'h1,
        OP_AND = 3'h2,
        OP_XOR = 3'h3,
        OP_NZT = 3'h4,
        OP_XMIT = 3'h5,
        OP_JMP = 3'h6,
        OP_NOP = 3'h7
    } opcode_e;

    typedef enum logic [0:0] {
        ST_FILL = 1'b0,
        ST_RUN = 1'b1
    } run_e;

    typedef struct packed {
        opcode_e op;
        logic [4:0] src;
        logic [2:0] rot;
        logic [4:0] dst;
    } instr_s;

    typedef struct packed {
        logic sc;
        logic wc;
        logic lb_n;
        logic rb_n;
    } bus_ctl_s;

    localparam bus_ctl_s BUS_IDLE = bus_ctl_s'(4'h3);

endpackage : mcu_core_pkg

// ---- mcu_far_side.sv ----
// ==========================================================
// Program store and two banked peripheral ports
// ==========================================================
module mcu_far_side (
    input wire logic [12:0] instruction_address_lines,
    output logic [15:0] instruction_word_lines,
    input wire logic [7:0] peripheral_vector_bus_out,
    input wire logic peripheral_vector_bus_oe,
    input wire logic left_port_group_enable_n,
    input wire logic right_port_group_enable_n,
    input wire logic [7:0] left_data,
    input wire logic [7:0] right_data,
    output logic [7:0] peripheral_vector_bus_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Loaded by the bench; upper address bits wrap onto 256 words
    logic [15:0] mem [256];

    assign instruction_word_lines = mem[instruction_address_lines[7:0]];

    // Ports answer low-true, only on their own bank, never over the core
    // banked port response
    always_comb begin
        if (peripheral_vector_bus_oe)
            peripheral_vector_bus_in = peripheral_vector_bus_out;
        else if (!left_port_group_enable_n)
            peripheral_vector_bus_in = ~left_data;
        else if (!right_port_group_enable_n)
            peripheral_vector_bus_in = ~right_data;
        else
            peripheral_vector_bus_in = 8'hFF; // Pull-up, nobody drives
    end
endmodule // mcu_far_side

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals
    // ==========================================================
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] left_data = 8'h00;
    logic [7:0] right_data = 8'h00;
    logic [15:0] iw;
    logic [12:0] ia;
    logic [7:0] bin, bout;
    logic oe, mclk, sc, wc, lbn, rbn;
    mcu_core_pkg::bus_ctl_s ctl, e_fh, e_sh;
    logic e_oe;
    logic [7:0] e_out;
    logic [12:0] e_nxt;
    logic [7:0] regs [16];
    int mismatches = 0;
    int n_compared = 0;
    // Corner cases: carry out, masked bus read, selects, both branches
    localparam logic [15:0] DIRECTED [12] = '{16'hA0FF, 16'hA101,
        16'h2102, 16'h0810, 16'h1867, 16'hAF5A, 16'h0138, 16'h8220,
        16'h810A, 16'hA3EE, 16'hE000, 16'hC010};

    assign ctl = {sc, wc, lbn, rbn};

    mcu_core uut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .instruction_address_lines(ia),
        .instruction_word_lines(iw),
        .peripheral_vector_bus_in(bin),
        .peripheral_vector_bus_out(bout),
        .peripheral_vector_bus_oe(oe),
        .port_select_command(sc),
        .bus_write_command(wc),
        .left_port_group_enable_n(lbn),
        .right_port_group_enable_n(rbn),
        .master_clock(mclk)
    );

    mcu_far_side far (
        .instruction_address_lines(ia),
        .instruction_word_lines(iw),
        .peripheral_vector_bus_out(bout),
        .peripheral_vector_bus_oe(oe),
        .left_port_group_enable_n(lbn),
        .right_port_group_enable_n(rbn),
        .left_data(left_data),
        .right_data(right_data),
        .peripheral_vector_bus_in(bin)
    );

    // Free-running system clock
    initial forever #(mcu_core_pkg::CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reference model: expected outputs and registers for one word
    task automatic execute(input logic [15:0] w, input logic [12:0] pc,
                           input logic [7:0] dl, input logic [7:0] dr);
        mcu_core_pkg::instr_s i;
        logic [15:0] rr;
        logic [8:0] s;
        logic [7:0] a, r, mk;
        logic [4:0] loc;
        i = w;
        rr = {regs[i.src[3:0]], regs[i.src[3:0]]} >> i.rot;
        mk = (i.rot == 3'h0) ? 8'hFF : 8'((9'h001 << i.rot) - 9'h001);
        a = i.src[4] ? ((i.src[3] ? dr : dl) & mk) : rr[7:0];
        s = {1'b0, a} + {1'b0, regs[0]};
        e_fh = mcu_core_pkg::BUS_IDLE;
        if (i.src[4] && i.op <= 3'h4) begin
            e_fh.lb_n = i.src[3];
            e_fh.rb_n = !i.src[3];
        end
        case (i.op)
            3'h0: r = a;
            3'h1: begin
                r = s[7:0];
                regs[8][0] = s[8];
            end
            3'h2: r = a & regs[0];
            3'h3: r = a ^ regs[0];
            default: r = w[7:0];
        endcase
        e_nxt = pc + 13'h0001;
        if (i.op == 3'h6) e_nxt = w[12:0];
        if (i.op == 3'h4 && a != 8'h00) e_nxt = {pc[12:8], w[7:0]};
        e_sh = mcu_core_pkg::BUS_IDLE;
        e_oe = 1'b0;
        e_out = 8'hFF;
        loc = (i.op == 3'h5) ? i.src : i.dst;
        if (i.op <= 3'h3 || i.op == 3'h5) begin
            // Bus writes and writes to the two select registers drive out
            if (loc[4] || loc[2:0] == 3'h7) begin
                e_oe = 1'b1;
                e_out = ~r;
                e_sh.sc = !loc[4];
                e_sh.wc = loc[4];
                e_sh.lb_n = loc[3];
                e_sh.rb_n = !loc[3];
            end
            if (!loc[4]) regs[loc[3:0]] = r;
        end
    endtask

    // ==========================================================
    // Stimulus
    // ==========================================================
    // Synchronous reset, entered on a rising edge
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        check("reset address", 32'(ia), 32'h0000_0000);
        check("reset outputs", 32'({mclk, ctl, oe, bout}),
              32'({1'b0, mcu_core_pkg::BUS_IDLE, 1'b0, 8'hFF}));
        foreach (regs[k]) regs[k] = 8'h00;
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    // One pass per instruction cycle; the first cycle after reset is a fill
    task automatic run(input int n);
        logic [12:0] pc;
        logic [7:0] dl, dr;
        logic fill;
        time t0;
        fill = 1'b1;
        pc = 13'h1FFF;
        t0 = 0;
        repeat (n) begin
            dl = 8'($urandom);
            dr = 8'($urandom);
            left_data <= dl;
            right_data <= dr;
            execute(fill ? 16'hE000 : far.mem[pc[7:0]], pc, dl, dr);
            repeat (8) @(posedge ref_clk);
            #1;
            check("first half", 32'({mclk, ctl}), 32'({1'b0, e_fh}));
            @(posedge mclk);
            if (!fill)
                check("cycle time", 32'($time - t0),
                      32'(mcu_core_pkg::CYCLE_NS));
            t0 = $time;
            repeat (2) @(posedge ref_clk);
            #1;
            check("second half", 32'(ctl), 32'(e_sh));
            check("bus drive", 32'({oe, bout}), 32'({e_oe, e_out}));
            check("fetch address", 32'(ia), 32'(e_nxt));
            pc = e_nxt;
            fill = 1'b0;
            @(negedge mclk);
            #1;
            check("cycle start idle", 32'({ctl, oe, bout}),
                  32'({mcu_core_pkg::BUS_IDLE, 1'b0, 8'hFF}));
            @(posedge ref_clk);
        end
    endtask

    // Random program body around the directed prefix, then two runs
    initial begin
        logic [15:0] w;
        void'($urandom(60));
        for (int k = 0; k < 256; k++) begin
            w = 16'($urandom);
            w[15:13] = 3'($urandom_range(5));
            // Register 8 holds only the carry; immediates never go to a bus port
            if (w[15:13] == 3'h5) w[12] = 1'b0;
            if (w[15:13] == 3'h5 && w[11:8] == 4'h8) w[8] = 1'b1;
            if (w[15:13] != 3'h5 && w[4:0] == 5'h08) w[0] = 1'b1;
            far.mem[k] = w;
        end
        foreach (DIRECTED[k]) far.mem[k] = DIRECTED[k];
        far.mem[255] = 16'hC000; // Wrap back to the start
        @(posedge ref_clk);
        do_reset();
        run(600);
        do_reset(); // Mid-run, during a first half
        run(80);
        test_done();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule // tb
